// ### design/sdrci_top.sv
`timescale 1ns/1ps
module sdrci_top #(
  parameter int NUM_BANKS = sdrci_pkg::NUM_BANKS,
  parameter int ROWS = sdrci_pkg::ROWS_PER_BANK,
  parameter logic [1:0] WIDTH_SEL = sdrci_pkg::WID_X16,
  parameter bit EXT_TEMP_GRADE = 1'b1,
  parameter int REFRESH_CYC = sdrci_pkg::REFRESH_CYC_AUTO
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cke_i,
  input wire logic cs_b_i,
  input wire logic ras_b_i,
  input wire logic cas_b_i,
  input wire logic we_b_i,
  input wire logic [sdrci_pkg::BANK_W-1:0] ba_i,
  input wire logic [sdrci_pkg::ADDR_W-1:0] addr_i,
  input wire logic dqm_i,
  input wire logic [2:0] burst_len_i,
  output logic [NUM_BANKS-1:0] bank_open_o,
  output logic [sdrci_pkg::ADDR_W-1:0] act_row_o,
  output logic [sdrci_pkg::BANK_W-1:0] burst_bank_o,
  output logic [sdrci_pkg::COL_W-1:0] burst_col_o,
  output logic burst_write_o,
  output logic burst_valid_o,
  output logic wr_data_en_o,
  output logic rd_out_en_o,
  output logic int_clk_en_o,
  output logic input_buf_en_o,
  output logic [2:0] pwr_state_o,
  output logic refresh_overdue_o,
  output logic self_ref_refused_o
);
  localparam int COL_W = sdrci_pkg::COL_W;
  localparam int RCW = $clog2(REFRESH_CYC + 1);

  // Pin inputs pass two flops; the second stage is the registered command.
  logic [3:0] cmd_s1;
  logic [3:0] cmd_s2;
  logic cke_s1;
  logic cke_s2;
  logic cke_prev;
  logic dqm_s1;
  logic dqm_s2;
  logic [sdrci_pkg::BANK_W-1:0] ba_s1;
  logic [sdrci_pkg::BANK_W-1:0] ba_s2;
  logic [sdrci_pkg::ADDR_W-1:0] addr_s1;
  logic [sdrci_pkg::ADDR_W-1:0] addr_s2;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_s1 <= sdrci_pkg::CMD_NOP | 4'h8;
      cmd_s2 <= sdrci_pkg::CMD_NOP | 4'h8;
      cke_s1 <= 1'b0;
      cke_s2 <= 1'b0;
      dqm_s1 <= 1'b0;
      dqm_s2 <= 1'b0;
      ba_s1 <= '0;
      ba_s2 <= '0;
      addr_s1 <= '0;
      addr_s2 <= '0;
    end else begin
      cmd_s1 <= {cs_b_i, ras_b_i, cas_b_i, we_b_i};
      cmd_s2 <= cmd_s1;
      cke_s1 <= cke_i;
      cke_s2 <= cke_s1;
      dqm_s1 <= dqm_i;
      dqm_s2 <= dqm_s1;
      ba_s1 <= ba_i;
      ba_s2 <= ba_s1;
      addr_s1 <= addr_i;
      addr_s2 <= addr_s1;
    end
  end

  function automatic logic [COL_W-1:0] col_mask(input logic [1:0] wsel);
    case (wsel)
      sdrci_pkg::WID_X4: col_mask = COL_W'(sdrci_pkg::COLS_X4 - 1);
      sdrci_pkg::WID_X8: col_mask = COL_W'(sdrci_pkg::COLS_X8 - 1);
      default: col_mask = COL_W'(sdrci_pkg::COLS_X16 - 1);
    endcase
  endfunction

  function automatic logic [COL_W-1:0] col_of(input logic [sdrci_pkg::ADDR_W-1:0] a,
                                               input logic [1:0] wsel);
    logic [COL_W-1:0] c;
    c = {a[sdrci_pkg::X4_HI_COL_BIT], a[9:0]};
    col_of = c & col_mask(wsel);
  endfunction

  logic [sdrci_pkg::BANK_W-1:0] cur_bank;
  logic [sdrci_pkg::BANK_W-1:0] next_cur_bank;
  logic cur_write;
  logic next_cur_write;
  logic cur_ap;
  logic next_cur_ap;
  logic [NUM_BANKS-1:0] open;
  logic [NUM_BANKS-1:0] next_open;
  logic [sdrci_pkg::ADDR_W-1:0] act_row;
  logic [sdrci_pkg::ADDR_W-1:0] next_act_row;
  sdrci_pkg::sdrci_pwr_t pwr;
  sdrci_pkg::sdrci_pwr_t next_pwr;
  logic [RCW-1:0] ref_cnt;
  logic [RCW-1:0] next_ref_cnt;
  logic refused;
  logic next_refused;
  logic [sdrci_pkg::DQM_LAT:0] dqm_pipe;
  logic [sdrci_pkg::DQM_LAT:0] next_dqm_pipe;

  logic run;
  logic dec_en;
  logic is_rd;
  logic is_wr;
  logic is_bst;
  logic ctr_load;
  logic ctr_stop;
  logic ctr_adv;
  logic ctr_busy;
  logic ctr_last;
  logic [COL_W-1:0] ctr_col;

  assign run = (pwr == sdrci_pkg::SDRCI_RUN) && cke_prev;
  assign dec_en = run && !cmd_s2[3];
  assign is_rd = dec_en && cmd_s2 == sdrci_pkg::CMD_RD;
  assign is_wr = dec_en && cmd_s2 == sdrci_pkg::CMD_WR;
  assign is_bst = dec_en && cmd_s2 == sdrci_pkg::CMD_BST;
  assign ctr_load = is_rd || is_wr;
  assign ctr_stop = is_bst;
  assign ctr_adv = run;

  sdrci_burst_ctr #(
    .COL_W(COL_W)
  ) u_ctr (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .adv_i(ctr_adv),
    .load_i(ctr_load),
    .stop_i(ctr_stop),
    .start_col_i(col_of(addr_s2, WIDTH_SEL)),
    .bl_i(burst_len_i),
    .col_mask_i(col_mask(WIDTH_SEL)),
    .col_o(ctr_col),
    .busy_o(ctr_busy),
    .last_o(ctr_last)
  );

  always_comb begin
    next_cur_bank = cur_bank;
    next_cur_write = cur_write;
    next_cur_ap = cur_ap;
    next_open = open;
    next_act_row = act_row;
    next_pwr = pwr;
    next_refused = 1'b0;
    next_ref_cnt = ref_cnt;
    next_dqm_pipe = dqm_pipe;
    if (ref_cnt != RCW'(REFRESH_CYC)) begin
      next_ref_cnt = ref_cnt + RCW'(1);
    end
    if (run) begin
      next_dqm_pipe = {dqm_pipe[sdrci_pkg::DQM_LAT-1:0], dqm_s2};
    end
    if (dec_en) begin
      case (cmd_s2)
        sdrci_pkg::CMD_ACT: begin
          next_open[ba_s2] = 1'b1;
          next_act_row = addr_s2;
        end
        sdrci_pkg::CMD_RD,
        sdrci_pkg::CMD_WR: begin
          next_cur_bank = ba_s2;
          next_cur_write = (cmd_s2 == sdrci_pkg::CMD_WR);
          next_cur_ap = addr_s2[sdrci_pkg::AP_BIT];
        end
        sdrci_pkg::CMD_PRE: begin
          if (addr_s2[sdrci_pkg::AP_BIT]) begin
            next_open = '0;
          end else begin
            next_open[ba_s2] = 1'b0;
          end
        end
        sdrci_pkg::CMD_REF: begin
          next_ref_cnt = '0;
        end
        default: begin
        end
      endcase
    end
    if (run && ctr_last && cur_ap && !ctr_load) begin
      next_open[cur_bank] = 1'b0;
    end
    case (pwr)
      sdrci_pkg::SDRCI_RUN: begin
        if (cke_prev && !cke_s2) begin
          if (ctr_busy) begin
            next_pwr = sdrci_pkg::SDRCI_SUSPEND;
          end else if (open != '0) begin
            next_pwr = sdrci_pkg::SDRCI_ACT_PD;
          end else if (!cmd_s2[3] && cmd_s2 == sdrci_pkg::CMD_REF) begin
            if (EXT_TEMP_GRADE) begin
              next_pwr = sdrci_pkg::SDRCI_PRE_PD;
              next_refused = 1'b1;
            end else begin
              next_pwr = sdrci_pkg::SDRCI_SELF_REF;
            end
          end else begin
            next_pwr = sdrci_pkg::SDRCI_PRE_PD;
          end
        end
      end
      default: begin
        if (cke_s2) begin
          next_pwr = sdrci_pkg::SDRCI_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cke_prev <= 1'b0;
      cur_bank <= '0;
      cur_write <= 1'b0;
      cur_ap <= 1'b0;
      open <= '0;
      act_row <= '0;
      pwr <= sdrci_pkg::SDRCI_RUN;
      ref_cnt <= '0;
      refused <= 1'b0;
      dqm_pipe <= '0;
    end else begin
      cke_prev <= cke_s2;
      cur_bank <= next_cur_bank;
      cur_write <= next_cur_write;
      cur_ap <= next_cur_ap;
      open <= next_open;
      act_row <= next_act_row;
      pwr <= next_pwr;
      ref_cnt <= next_ref_cnt;
      refused <= next_refused;
      dqm_pipe <= next_dqm_pipe;
    end
  end

  logic [NUM_BANKS-1:0] next_bank_open_o;
  logic [sdrci_pkg::ADDR_W-1:0] next_act_row_o;
  logic [sdrci_pkg::BANK_W-1:0] next_burst_bank_o;
  logic [COL_W-1:0] next_burst_col_o;
  logic next_burst_write_o;
  logic next_burst_valid_o;
  logic next_wr_data_en_o;
  logic next_rd_out_en_o;
  logic next_int_clk_en_o;
  logic next_input_buf_en_o;
  logic [2:0] next_pwr_state_o;
  logic next_refresh_overdue_o;
  logic next_self_ref_refused_o;

  // Output values, all taken from the registered state.
  always_comb begin
    next_bank_open_o = open;
    next_act_row_o = act_row;
    next_burst_bank_o = cur_bank;
    next_burst_col_o = ctr_col;
    next_burst_write_o = cur_write;
    next_burst_valid_o = ctr_busy && run;
    // The burst column lags the command by one stage, so the mask of a beat sits in stage 0.
    // A read mask acts two clocks later than that, which is the last stage of the pipe.
    // write mask
    next_wr_data_en_o = ctr_busy && run && cur_write && !dqm_pipe[0];
    next_rd_out_en_o = ctr_busy && run && !cur_write && !dqm_pipe[sdrci_pkg::DQM_LAT];
    next_int_clk_en_o = run;
    next_input_buf_en_o = (pwr == sdrci_pkg::SDRCI_RUN) || (pwr == sdrci_pkg::SDRCI_SUSPEND);
    next_pwr_state_o = pwr;
    next_refresh_overdue_o = (ref_cnt == RCW'(REFRESH_CYC));
    next_self_ref_refused_o = refused;
  end

  // Output registers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bank_open_o <= '0;
      act_row_o <= '0;
      burst_bank_o <= '0;
      burst_col_o <= '0;
      burst_write_o <= 1'b0;
      burst_valid_o <= 1'b0;
      wr_data_en_o <= 1'b0;
      rd_out_en_o <= 1'b0;
      int_clk_en_o <= 1'b0;
      input_buf_en_o <= 1'b0;
      pwr_state_o <= '0;
      refresh_overdue_o <= 1'b0;
      self_ref_refused_o <= 1'b0;
    end else begin
      bank_open_o <= next_bank_open_o;
      act_row_o <= next_act_row_o;
      burst_bank_o <= next_burst_bank_o;
      burst_col_o <= next_burst_col_o;
      burst_write_o <= next_burst_write_o;
      burst_valid_o <= next_burst_valid_o;
      wr_data_en_o <= next_wr_data_en_o;
      rd_out_en_o <= next_rd_out_en_o;
      int_clk_en_o <= next_int_clk_en_o;
      input_buf_en_o <= next_input_buf_en_o;
      pwr_state_o <= next_pwr_state_o;
      refresh_overdue_o <= next_refresh_overdue_o;
      self_ref_refused_o <= next_self_ref_refused_o;
    end
  end
endmodule // sdrci_top

// ### design/sdrci_pkg.sv
package sdrci_pkg;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int ROWS_PER_BANK = 8192;
  localparam int COLS_X4 = 2048;
  localparam int COLS_X8 = 1024;
  localparam int COLS_X16 = 512;
  localparam int COL_W = 11;
  localparam int AP_BIT = 10;
  localparam int X4_HI_COL_BIT = 11;
  localparam int DQM_LAT = 2;
  localparam int DQM_LAT_W = 2;
  // Burst length codes as carried on the burst length port.
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  // Data width variant codes.
  localparam logic [1:0] WID_X4 = 2'h0;
  localparam logic [1:0] WID_X8 = 2'h1;
  localparam logic [1:0] WID_X16 = 2'h2;
  // Command code {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int REFRESH_MS_AUTO = 16;
  localparam int CLK_MHZ = 20;
  localparam int REFRESH_CYC_AUTO = REFRESH_MS_AUTO * 1000 * CLK_MHZ;
  typedef enum logic [2:0] {
    SDRCI_RUN,
    SDRCI_PRE_PD,
    SDRCI_ACT_PD,
    SDRCI_SELF_REF,
    SDRCI_SUSPEND
  } sdrci_pwr_t;
endpackage

// ### design/sdrci_burst_ctr.sv
`timescale 1ns/1ps
// Column generator for one burst: sequential wrap inside the burst block.
module sdrci_burst_ctr #(
  parameter int COL_W = 11
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic adv_i,
  input wire logic load_i,
  input wire logic stop_i,
  input wire logic [COL_W-1:0] start_col_i,
  input wire logic [2:0] bl_i,
  input wire logic [COL_W-1:0] col_mask_i,
  output logic [COL_W-1:0] col_o,
  output logic busy_o,
  output logic last_o
);
  logic [COL_W-1:0] col;
  logic [COL_W-1:0] next_col;
  logic [COL_W-1:0] left;
  logic [COL_W-1:0] next_left;
  logic busy;
  logic next_busy;
  logic [COL_W-1:0] wrap;
  logic [COL_W:0] blen;

  always_comb begin
    case (bl_i)
      sdrci_pkg::BL_1: blen = (COL_W+1)'(1);
      sdrci_pkg::BL_2: blen = (COL_W+1)'(2);
      sdrci_pkg::BL_4: blen = (COL_W+1)'(4);
      sdrci_pkg::BL_8: blen = (COL_W+1)'(8);
      default: blen = {1'b0, col_mask_i} + (COL_W+1)'(1);
    endcase
    wrap = blen[COL_W-1:0] - COL_W'(1);
    next_col = col;
    next_left = left;
    next_busy = busy;
    if (load_i) begin
      next_col = start_col_i & col_mask_i;
      next_left = COL_W'(blen - (COL_W+1)'(1));
      next_busy = 1'b1;
    end else if (stop_i) begin
      next_busy = 1'b0;
    end else if (adv_i && busy) begin
      if (left == '0 && bl_i != sdrci_pkg::BL_PAGE) begin
        next_busy = 1'b0;
      end else begin
        next_col = ((col & ~wrap) | ((col + COL_W'(1)) & wrap)) & col_mask_i;
        next_left = left - COL_W'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      col <= '0;
      left <= '0;
      busy <= 1'b0;
    end else begin
      col <= next_col;
      left <= next_left;
      busy <= next_busy;
    end
  end

  assign col_o = col;
  assign busy_o = busy;
  assign last_o = busy && left == '0 && bl_i != sdrci_pkg::BL_PAGE;
endmodule // sdrci_burst_ctr

// ### verif/sdrci_ctrl_model.sv
`timescale 1ns/1ps
module sdrci_ctrl_model (
  input wire logic clk_i,
  output logic cs_b_o,
  output logic ras_b_o,
  output logic cas_b_o,
  output logic we_b_o,
  output logic [1:0] ba_o,
  output logic [12:0] addr_o
);
  initial begin
    {cs_b_o, ras_b_o, cas_b_o, we_b_o} = 4'hF;
    ba_o = 2'h0;
    addr_o = 13'h0000;
  end
  // command as one code: strobes, bank and address stand for one edge.
  task automatic issue(input logic [3:0] cmd, input logic [1:0] ba, input logic [12:0] addr);
    {cs_b_o, ras_b_o, cas_b_o, we_b_o} = cmd;
    ba_o = ba;
    addr_o = addr;
    @(posedge clk_i);
    #1;
  endtask
  // Deselected lines show the inverse of the last value so a stale copy can never look valid.
  task automatic idle();
    {cs_b_o, ras_b_o, cas_b_o, we_b_o} = 4'hF;
    ba_o = ~ba_o;
    addr_o = ~addr_o;
    @(posedge clk_i);
    #1;
  endtask
endmodule // sdrci_ctrl_model

// ### verif/sdrci_top_properties.sv
`timescale 1ns/1ps
module sdrci_top_chk #(
  parameter int NUM_BANKS = 4,
  parameter bit EXT_TEMP_GRADE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cke_i,
  input wire logic cs_b_i,
  input wire logic [2:0] burst_len_i,
  input wire logic [NUM_BANKS-1:0] bank_open_o,
  input wire logic [10:0] burst_col_o,
  input wire logic burst_write_o,
  input wire logic burst_valid_o,
  input wire logic wr_data_en_o,
  input wire logic rd_out_en_o,
  input wire logic int_clk_en_o,
  input wire logic input_buf_en_o,
  input wire logic [2:0] pwr_state_o,
  input wire logic self_ref_refused_o
);
  // Seven deselected running cycles mean no command can restart or stop the burst in flight.
  logic [2:0] quiet;
  logic [2:0] next_quiet;
  always_comb begin
    next_quiet = 3'h0;
    if (cs_b_i && cke_i) begin
      next_quiet = (quiet == 3'h7) ? quiet : quiet + 3'h1;
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      quiet <= 3'h0;
    end else begin
      quiet <= next_quiet;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // A burst that resumes after a clock stop is not a new command.
  a_burst_needs_cs: assert property (
    $rose(burst_valid_o) && $past(int_clk_en_o) |-> !$past(cs_b_i, 3) || !$past(cs_b_i, 4)
      || !$past(cs_b_i, 5)) else $error("burst started without a selected command");
  a_open_needs_cs: assert property (
    |(bank_open_o & ~$past(bank_open_o)) |-> !$past(cs_b_i, 3) || !$past(cs_b_i, 4)
      || !$past(cs_b_i, 5)) else $error("row opened without a selected command");
  a_col_step: assert property (
    quiet == 3'h7 && burst_valid_o && $past(burst_valid_o) && burst_len_i != sdrci_pkg::BL_1
      |-> burst_col_o[0] != $past(burst_col_o[0])) else $error("burst column did not advance");
  a_wr_beat: assert property (
    wr_data_en_o |-> burst_valid_o && burst_write_o) else $error("write enable off a write beat");
  a_rd_beat: assert property (
    rd_out_en_o |-> burst_valid_o && !burst_write_o) else $error("read drive off a read beat");
  a_refuse_once: assert property (
    self_ref_refused_o |=> !self_ref_refused_o) else $error("refusal pulse too long");
  a_no_self_ref: assert property (
    EXT_TEMP_GRADE |-> pwr_state_o != 3'h3) else $error("self refresh on extended grade");
  a_cke_stops: assert property (
    !cke_i [*6] |-> !int_clk_en_o) else $error("internal clock runs with enable low");
  a_cke_runs: assert property (
    cke_i [*7] |-> int_clk_en_o) else $error("internal clock stopped with enable high");
  a_buf_off: assert property (
    pwr_state_o inside {3'h1, 3'h2, 3'h3} |-> !input_buf_en_o)
    else $error("input buffers on in low power");
  c_write: cover property (burst_valid_o && burst_write_o);
  c_refused: cover property (self_ref_refused_o);
  c_suspend: cover property (pwr_state_o == 3'h4);
endmodule // sdrci_top_chk
bind sdrci_top sdrci_top_chk #(.NUM_BANKS(NUM_BANKS), .EXT_TEMP_GRADE(EXT_TEMP_GRADE))
  u_sdrci_top_chk (.*);

// ### verif/sdr_sdram_command_interface_bench.sv
`timescale 1ns/1ps
module sdr_sdram_command_interface_bench;
  localparam logic [3:0] ACT = sdrci_pkg::CMD_ACT;
  localparam logic [3:0] RD = sdrci_pkg::CMD_RD;
  localparam logic [3:0] PRE = sdrci_pkg::CMD_PRE;
  localparam logic [3:0] BST = sdrci_pkg::CMD_BST;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cke_i = 1'b1;
  logic dqm_i = 1'b0;
  logic [2:0] burst_len_i = sdrci_pkg::BL_4;
  logic cs_b_i, ras_b_i, cas_b_i, we_b_i;
  logic [1:0] ba_i, burst_bank_o;
  logic [12:0] addr_i, act_row_o;
  logic [3:0] bank_open_o;
  logic [10:0] burst_col_o;
  logic burst_write_o, burst_valid_o, wr_data_en_o, rd_out_en_o, int_clk_en_o;
  logic input_buf_en_o, refresh_overdue_o, self_ref_refused_o;
  logic [2:0] pwr_state_o;
  int miscompares = 0;
  int total_checks = 0;
  always #25 clk_i = ~clk_i;
  sdrci_top #(.REFRESH_CYC(50)) u_sdrci_top (.*);
  sdrci_ctrl_model u_sdrci_ctrl_model (.clk_i(clk_i), .cs_b_o(cs_b_i), .ras_b_o(ras_b_i),
    .cas_b_o(cas_b_i), .we_b_o(we_b_i), .ba_o(ba_i), .addr_o(addr_i));
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    u_sdrci_ctrl_model.issue(c, b, a);
    u_sdrci_ctrl_model.idle();
  endtask
  task automatic wait_valid();
    for (int n = 0; n < 10 && burst_valid_o !== 1'b1; n++) tick();
  endtask
  task automatic wait_st(input logic [2:0] s);
    for (int n = 0; n < 12 && pwr_state_o !== s; n++) tick();
  endtask
  task automatic t_reset();
    repeat (10) tick();
    chk(bank_open_o, 13'h0);
    chk(pwr_state_o, 13'h0);
    rst_b_i = 1'b1;
    for (int n = 0; n < 10 && int_clk_en_o !== 1'b1; n++) tick();
    chk(int_clk_en_o, 13'h1);
    chk(input_buf_en_o, 13'h1);
  endtask
  task automatic t_open_and_mask();
    cmd(ACT, 2'h1, 13'h1FFF);
    for (int n = 0; n < 8 && bank_open_o !== 4'h2; n++) tick();
    chk(bank_open_o, 13'h2);
    chk(act_row_o, 13'h1FFF);
    cmd({1'b1, ACT[2:0]}, 2'h0, 13'h0123);
    repeat (6) tick();
    chk(bank_open_o, 13'h2);
    chk(act_row_o, 13'h1FFF);
  endtask
  task automatic t_read_ap();
    logic [10:0] exp [4] = '{11'h005, 11'h006, 11'h007, 11'h004};
    logic rd_exp [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    // The row is open before the read, and A9 lies above the narrow column field.
    // The mask raised with the command floats the third beat, two clocks on.
    dqm_i = 1'b1;
    u_sdrci_ctrl_model.issue(RD, 2'h1, 13'h0605);
    dqm_i = 1'b0;
    u_sdrci_ctrl_model.idle();
    wait_valid();
    chk(burst_bank_o, 13'h1);
    chk(burst_write_o, 13'h0);
    for (int i = 0; i < 4; i++) begin
      chk(burst_col_o, exp[i]);
      chk(rd_out_en_o, 13'(rd_exp[i]));
      tick();
    end
    for (int n = 0; n < 6 && bank_open_o !== 4'h0; n++) tick();
    chk(bank_open_o, 13'h0);
  endtask
  task automatic t_lengths();
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
    int beats [4] = '{1, 2, 4, 8};
    int n;
    cmd(ACT, 2'h2, 13'h0042);
    repeat (6) tick();
    for (int i = 0; i < 5; i++) begin
      burst_len_i = codes[i];
      cmd(RD, 2'h2, 13'h0010);
      wait_valid();
      n = 0;
      if (i < 4) begin
        while (burst_valid_o === 1'b1 && n < 20) begin
          n++;
          tick();
        end
        chk(13'(n), 13'(beats[i]));
      end else begin
        repeat (9) tick();
        chk(burst_valid_o, 13'h1);
        cmd(BST, 2'h2, 13'h0000);
        repeat (6) tick();
        chk(burst_valid_o, 13'h0);
      end
      repeat (3) tick();
    end
  endtask
  task automatic t_write_b2b();
    burst_len_i = sdrci_pkg::BL_1;
    dqm_i = 1'b1;
    u_sdrci_ctrl_model.issue(sdrci_pkg::CMD_WR, 2'h2, 13'h000A);
    dqm_i = 1'b0;
    cmd(sdrci_pkg::CMD_WR, 2'h2, 13'h0014);
    wait_valid();
    chk(burst_write_o, 13'h1);
    chk(burst_col_o, 13'h00A);
    chk(wr_data_en_o, 13'h0);
    tick();
    chk(burst_col_o, 13'h014);
    chk(wr_data_en_o, 13'h1);
    repeat (4) tick();
  endtask
  task automatic t_precharge();
    u_sdrci_ctrl_model.issue(ACT, 2'h0, 13'h0001);
    cmd(ACT, 2'h3, 13'h0002);
    repeat (6) tick();
    chk(bank_open_o, 13'hD);
    u_sdrci_ctrl_model.issue(PRE, 2'h3, 13'h0000);
    cmd(RD, 2'h0, 13'h0003);
    wait_valid();
    chk(burst_bank_o, 13'h0);
    repeat (4) tick();
    chk(bank_open_o, 13'h5);
    cmd(PRE, 2'h0, 13'h0400);
    repeat (6) tick();
    chk(bank_open_o, 13'h0);
  endtask
  task automatic t_power();
    logic seen = 1'b0;
    cke_i = 1'b0;
    wait_st(3'h1);
    chk(pwr_state_o, 13'h1);
    chk(input_buf_en_o, 13'h0);
    cke_i = 1'b1;
    wait_st(3'h0);
    chk(pwr_state_o, 13'h0);
    cmd(ACT, 2'h0, 13'h0005);
    repeat (6) tick();
    cke_i = 1'b0;
    wait_st(3'h2);
    chk(pwr_state_o, 13'h2);
    cke_i = 1'b1;
    wait_st(3'h0);
    burst_len_i = sdrci_pkg::BL_PAGE;
    cmd(RD, 2'h0, 13'h0000);
    wait_valid();
    cke_i = 1'b0;
    wait_st(3'h4);
    chk(pwr_state_o, 13'h4);
    cke_i = 1'b1;
    wait_st(3'h0);
    u_sdrci_ctrl_model.issue(BST, 2'h0, 13'h0000);
    cmd(PRE, 2'h0, 13'h0400);
    repeat (6) tick();
    cke_i = 1'b0;
    cmd(sdrci_pkg::CMD_REF, 2'h0, 13'h0000);
    for (int n = 0; n < 10; n++) begin
      seen |= self_ref_refused_o;
      tick();
    end
    chk(seen, 13'h1);
    chk(pwr_state_o, 13'h1);
    cke_i = 1'b1;
    wait_st(3'h0);
  endtask
  task automatic t_refresh();
    cmd(sdrci_pkg::CMD_REF, 2'h0, 13'h0000);
    repeat (6) tick();
    chk(refresh_overdue_o, 13'h0);
    repeat (60) tick();
    chk(refresh_overdue_o, 13'h1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The scenarios need well under a thousand cycles, so twenty thousand marks a hang.
  initial begin
    #(50 * 20000);
    miscompares++;
    results();
  end
  initial begin
    tick();
    t_reset();
    t_open_and_mask();
    t_read_ap();
    t_lengths();
    t_write_b2b();
    t_precharge();
    t_power();
    t_refresh();
    results();
  end
endmodule // sdr_sdram_command_interface_bench
